// File: bench/flash_model.sv
// behavioural parallel nor flash answering with a pattern of its address
module flash_model (
	input wire [28:0] flash_addr,
	input wire flash_output_en_n,
	input wire flash_chip_sel_n,
	output logic [15:0] flash_dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// read path
	// ****************
	// a deselected bus shows the inverse pattern, so a stale word cannot pass
	assign flash_dq_in = (flash_chip_sel_n || flash_output_en_n) ?
		~(flash_addr[15:0] ^ 16'h5a5a) : (flash_addr[15:0] ^ 16'h5a5a);
endmodule // flash_model

// File: bench/pflash_checker.sv
// assertion checker for the parallel flash read sequencer
`include "pflash_consts.vh"
module pflash_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire cfg_clk,
	input wire addr_valid_n,
	input wire [28:0] flash_addr,
	input wire [15:0] flash_dq_out,
	input wire flash_dq_oe,
	input wire flash_write_en_n,
	input wire flash_output_en_n,
	input wire flash_chip_sel_n,
	input wire cfg_word_valid,
	input wire cfg_done,
	input wire fallback_start,
	input wire read_error
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************
	// flash link
	// ****************
	we_gate_a: assert property (!flash_write_en_n |-> flash_dq_oe && flash_output_en_n)
		else $error("write strobe without driven bus");
	read_sel_a: assert property (!flash_output_en_n |->
		!flash_chip_sel_n && flash_write_en_n && !flash_dq_oe)
		else $error("read without chip select");
	write_cmd_a: assert property ($fell(flash_write_en_n) |->
		flash_dq_out == `CMD_CFG_SETUP || flash_dq_out == `CMD_CFG_CONFIRM)
		else $error("bad command on write");
	addr_step_a: assert property (!flash_output_en_n && !$past(flash_output_en_n) &&
		$changed(flash_addr) && flash_addr != 29'h0 |->
		flash_addr == $past(flash_addr) + 29'h1)
		else $error("address did not step by one");
	capture_edge_a: assert property (cfg_word_valid |-> cfg_clk && !flash_output_en_n)
		else $error("word taken off the rising phase");
	adv_burst_a: assert property ($fell(addr_valid_n) |->
		flash_addr == 29'h0 && !flash_dq_oe && !flash_output_en_n)
		else $error("burst start not at address zero");
	fallback_a: assert property (fallback_start |-> ##[0:1] read_error)
		else $error("fallback without error flag");
	err_hold_a: assert property (read_error |=> read_error)
		else $error("error flag dropped");
	done_stop_a: assert property ($rose(cfg_done) && !flash_output_en_n |->
		##[1:2] flash_output_en_n && flash_chip_sel_n)
		else $error("reading went on after completion");
	slverr_phase_a: assert property (pslverr |-> psel && penable && pready)
		else $error("error outside access phase");
	cover property ($fell(flash_write_en_n));
	cover property ($fell(addr_valid_n));
	cover property (cfg_word_valid);
endmodule // pflash_checker

bind parallel_flash_read_sequencer pflash_checker pflash_checker_i (.pclk, .presetn, .psel,
	.penable, .pready, .pslverr, .cfg_clk, .addr_valid_n, .flash_addr, .flash_dq_out,
	.flash_dq_oe, .flash_write_en_n, .flash_output_en_n, .flash_chip_sel_n, .cfg_word_valid,
	.cfg_done, .fallback_start, .read_error);

// File: bench/tb_parallel_flash_read_sequencer.sv
// self-checking bench for the parallel flash read sequencer
`include "pflash_consts.vh"
module tb_parallel_flash_read_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [15:0] CA = 16'h1000;
	localparam [15:0] CB = 16'h2000;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic parallel_flash_mode = 1'h0, set_valid = 1'h0, sync_req = 1'h0, cfg_done = 1'h0, err;
	logic [7:0] paddr = 8'h00, set_div = 8'h04;
	logic [31:0] pwdata = 32'h0, q, prdata;
	logic [1:0] set_page = 2'h0, set_first = 2'h0;
	logic [15:0] flash_dq_in, flash_dq_out, cfg_word, a;
	logic [28:0] flash_addr;
	logic pready, pslverr, irq, cfg_clk, addr_valid_n, flash_dq_oe, flash_write_en_n;
	logic flash_output_en_n, flash_chip_sel_n, cfg_word_valid, fallback_start, read_error;
	int failures = 0, tests_run = 0, i, n;

	parallel_flash_read_sequencer #(.SYNC_CFG_A(CA), .SYNC_CFG_B(CB))
		parallel_flash_read_sequencer_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .irq, .parallel_flash_mode, .cfg_clk,
		.addr_valid_n, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe,
		.flash_write_en_n, .flash_output_en_n, .flash_chip_sel_n, .cfg_word, .cfg_word_valid,
		.set_valid, .set_page, .set_first, .set_div, .sync_req, .cfg_done, .fallback_start,
		.read_error);
	flash_model flash_model_i (.flash_addr, .flash_output_en_n, .flash_chip_sel_n, .flash_dq_in);

	initial forever #25 pclk = ~pclk;
	// ****************
	// tasks
	// ****************
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		#1;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wv;
		do @(posedge pclk); while (cfg_word_valid !== 1'h1);
	endtask
	task setp(input logic [1:0] p, input logic [1:0] f, input logic [7:0] dv);
		@(posedge pclk);
		set_page <= p;
		set_first <= f;
		set_div <= dv;
		set_valid <= 1'h1;
		@(posedge pclk) set_valid <= 1'h0;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ****************
	// tests
	// ****************
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `OFS_CTRL, 32'h0);
		chk(q, 32'h0);
		apb(1'h0, `OFS_STATUS, 32'h0);
		chk(q, 32'h800);
		chk({flash_write_en_n, flash_output_en_n, flash_chip_sel_n, addr_valid_n}, 4'hf);
		apb(1'h0, 8'h20, 32'h0);
		chk(q, 32'h0);
		chk(err, 1'h1);
		@(posedge pclk);
		parallel_flash_mode <= 1'h1;
		for (i = 0; i < 3; i++) begin
			wv;
			chk(cfg_word, i[15:0] ^ 16'h5a5a);
			chk({flash_write_en_n, flash_output_en_n, flash_chip_sel_n}, 3'h4);
		end
		sync_req <= 1'h1;
		@(posedge pclk) sync_req <= 1'h0;
		wv;
		apb(1'h0, `OFS_STATUS, 32'h0);
		chk(q[3], 1'h0);
		for (i = 0; i < 2; i++) begin
			setp(i ? 2'h3 : `PAGE_1, i ? `FIRST_1 : 2'h1, 8'h04);
			apb(1'h0, `OFS_IRQ_STAT, 32'h0);
			chk(q[3], 1'h1);
			chk(irq, 1'h0);
			apb(1'h1, `OFS_IRQ_EN, 32'h8);
			chk(irq, 1'h1);
			apb(1'h1, `OFS_IRQ_CLR, 32'h8);
			chk(irq, 1'h0);
			apb(1'h1, `OFS_IRQ_EN, 32'h0);
		end
		setp(`PAGE_4, 2'h3, 8'h02);
		apb(1'h0, `OFS_STATUS, 32'h0);
		chk(q & 32'h1fff8, 32'h5a0);
		wv;
		wv;
		for (i = 0; i < 8; i++) begin
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (cfg_word_valid !== 1'h1);
			a = cfg_word ^ 16'h5a5a;
			chk(n, (a[1:0] == 2'h0) ? 16 : 4);
		end
		setp(`PAGE_8, 2'h3, 8'h02);
		apb(1'h0, `OFS_STATUS, 32'h0);
		chk(q & 32'h1fff8, 32'h5c0);
		@(posedge pclk);
		cfg_done <= 1'h1;
		repeat (3) @(posedge pclk);
		chk({flash_output_en_n, flash_chip_sel_n}, 2'h3);
		apb(1'h0, `OFS_IRQ_STAT, 32'h0);
		chk(q[0], 1'h1);
		for (i = 0; i < 2; i++) begin
			@(posedge pclk);
			cfg_done <= 1'h0;
			presetn <= 1'h0;
			repeat (2) @(posedge pclk);
			presetn <= 1'h1;
			apb(1'h0, `OFS_STATUS, 32'h0);
			chk(q & 32'h1fff8, 32'h800);
			apb(1'h1, `OFS_CTRL, {30'h0, i[0], 1'h1});
			wv;
			sync_req <= 1'h1;
			@(posedge pclk) sync_req <= 1'h0;
			do @(posedge pclk); while (flash_write_en_n !== 1'h0);
			chk(flash_addr, i ? CB : CA);
			chk(flash_dq_out, `CMD_CFG_SETUP);
			do @(posedge pclk); while (flash_write_en_n !== 1'h1);
			do @(posedge pclk); while (flash_write_en_n !== 1'h0);
			chk(flash_dq_out, `CMD_CFG_CONFIRM);
			do @(posedge pclk); while (addr_valid_n !== 1'h0);
			chk(flash_addr, 29'h0);
			wv;
			chk(cfg_word, 16'h5a5a);
			apb(1'h0, `OFS_STATUS, 32'h0);
			chk(q[3], 1'h1);
			apb(1'h0, `OFS_IRQ_STAT, 32'h0);
			chk(q[2], 1'h1);
		end
		report_and_stop;
	end
	initial begin
		#1ms;
		failures++;
		report_and_stop;
	end
endmodule // tb_parallel_flash_read_sequencer

// File: core/parallel_flash_read_sequencer.v
// configuration read engine for an external parallel nor flash
//
// The register offsets and the APB slave port were decided locally.
`include "pflash_consts.vh"

module parallel_flash_read_sequencer #(
	parameter [15:0] SYNC_CFG_A = 16'h1000,
	parameter [15:0] SYNC_CFG_B = 16'h2000,
	parameter [2:0] SYNC_LAT_A = 3'h3,
	parameter [2:0] SYNC_LAT_B = 3'h4
) (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output wire irq,
	input wire parallel_flash_mode,
	output reg cfg_clk,
	output reg addr_valid_n,
	output reg [28:0] flash_addr,
	input wire [15:0] flash_dq_in,
	output reg [15:0] flash_dq_out,
	output reg flash_dq_oe,
	output reg flash_write_en_n,
	output reg flash_output_en_n,
	output reg flash_chip_sel_n,
	output reg [15:0] cfg_word,
	output reg cfg_word_valid,
	input wire set_valid,
	input wire [1:0] set_page,
	input wire [1:0] set_first,
	input wire [7:0] set_div,
	input wire sync_req,
	input wire cfg_done,
	output reg fallback_start,
	output reg read_error
);
	// ***********************************
	// states
	// ***********************************
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_READ = 3'h1;
	localparam [2:0] S_WR1 = 3'h2;
	localparam [2:0] S_WR2 = 3'h3;
	localparam [2:0] S_DONE = 3'h4;
	localparam [2:0] S_FAIL = 3'h5;

	reg [2:0] state_r;
	reg [1:0] ctrl_r;
	reg [`IRQ_W-1:0] irq_stat_r;
	reg [`IRQ_W-1:0] irq_stat_nxt;
	reg [`IRQ_W-1:0] irq_en_r;
	reg [1:0] page_r;
	reg [1:0] first_r;
	reg [7:0] div_r;
	reg [7:0] div_cnt_r;
	reg [2:0] wait_r;
	reg sync_mode_r;
	reg sync_pend_r;
	reg wr_ph_r;
	reg ev_done;
	reg ev_err;
	reg ev_sync;
	reg ev_rej;

	wire [15:0] dq_s;
	wire mode_s;
	wire half_tick;
	wire rise_tick;
	wire [28:0] addr_inc;
	wire page_inner;
	wire [2:0] first_lat;
	wire [2:0] sync_lat;
	wire [15:0] sync_cfg;
	wire set_bad;
	wire wr_acc;
	wire rd_setup;

	// ***********************************
	// pin synchronisers
	// ***********************************
	sync2 #(
		.WIDTH(17)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({parallel_flash_mode, flash_dq_in}),
		.q({mode_s, dq_s})
	);

	function reg_hit;
		input [7:0] a;
		begin
			reg_hit = (a == `OFS_CTRL) || (a == `OFS_STATUS) || (a == `OFS_IRQ_STAT) ||
				(a == `OFS_IRQ_CLR) || (a == `OFS_IRQ_EN) || (a == `OFS_ADDR);
		end
	endfunction

	// ***********************************
	// cfg_clk divider
	// ***********************************
	assign half_tick = (div_cnt_r >= div_r - 8'h01);
	assign rise_tick = half_tick && !cfg_clk;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= 8'h00;
			cfg_clk <= 1'b0;
		end else if (half_tick) begin
			div_cnt_r <= 8'h00;
			cfg_clk <= !cfg_clk;
		end else begin
			div_cnt_r <= div_cnt_r + 8'h01;
		end
	end

	// ***********************************
	// image settings
	// ***********************************
	// page size one forbids any latency but one; unused encodings refused too
	assign set_bad = (set_page == 2'h3) || (set_div == 8'h00) ||
		((set_page == `PAGE_1) && (set_first != `FIRST_1));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_r <= `PAGE_1;
			first_r <= `FIRST_1;
			div_r <= `DIV_RESET;
		end else if (set_valid && !set_bad) begin
			page_r <= set_page;
			first_r <= set_first;
			div_r <= set_div;
		end
	end

	always @* begin
		ev_rej = set_valid && set_bad;
	end

	assign first_lat = {1'b0, first_r} + 3'h1;
	assign sync_lat = ctrl_r[`CTRL_SETTING] ? SYNC_LAT_B : SYNC_LAT_A;
	assign sync_cfg = ctrl_r[`CTRL_SETTING] ? SYNC_CFG_B : SYNC_CFG_A;
	assign addr_inc = flash_addr + 29'h00000001;
	// next word stays inside the current page
	assign page_inner = (page_r == `PAGE_4) ? (addr_inc[1:0] != 2'h0) :
		(page_r == `PAGE_8) ? (addr_inc[2:0] != 3'h0) : 1'b0;

	// ***********************************
	// fetch sequencer
	// ***********************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_IDLE;
			flash_addr <= 29'h00000000;
			flash_dq_out <= 16'h0000;
			flash_dq_oe <= 1'b0;
			flash_write_en_n <= 1'b1;
			flash_output_en_n <= 1'b1;
			flash_chip_sel_n <= 1'b1;
			addr_valid_n <= 1'b1;
			cfg_word <= 16'h0000;
			cfg_word_valid <= 1'b0;
			wait_r <= 3'h1;
			sync_mode_r <= 1'b0;
			sync_pend_r <= 1'b0;
			wr_ph_r <= 1'b0;
			fallback_start <= 1'b0;
			read_error <= 1'b0;
			ev_done <= 1'b0;
			ev_err <= 1'b0;
			ev_sync <= 1'b0;
		end else begin
			cfg_word_valid <= 1'b0;
			fallback_start <= 1'b0;
			ev_done <= 1'b0;
			ev_err <= 1'b0;
			ev_sync <= 1'b0;
			if (sync_req && ctrl_r[`CTRL_SYNC_EN] && !sync_mode_r && state_r == S_READ) begin
				sync_pend_r <= 1'b1;
			end
			case (state_r)
				S_IDLE: begin
					if (mode_s && rise_tick) begin
						flash_chip_sel_n <= 1'b0;
						flash_output_en_n <= 1'b0;
						flash_write_en_n <= 1'b1;
						flash_addr <= 29'h00000000;
						wait_r <= first_lat;
						state_r <= S_READ;
					end
				end
				S_READ: begin
					if (cfg_done) begin
						flash_output_en_n <= 1'b1;
						flash_chip_sel_n <= 1'b1;
						addr_valid_n <= 1'b1;
						ev_done <= 1'b1;
						state_r <= S_DONE;
					end else if (rise_tick) begin
						addr_valid_n <= 1'b1;
						if (sync_pend_r) begin
							// asynchronous write of the flash configuration register
							sync_pend_r <= 1'b0;
							flash_output_en_n <= 1'b1;
							flash_write_en_n <= 1'b0;
							flash_dq_oe <= 1'b1;
							flash_dq_out <= `CMD_CFG_SETUP;
							flash_addr <= {13'h0000, sync_cfg};
							wr_ph_r <= 1'b0;
							state_r <= S_WR1;
						end else if (wait_r > 3'h1) begin
							wait_r <= wait_r - 3'h1;
						end else begin
							cfg_word <= dq_s;
							cfg_word_valid <= 1'b1;
							if (flash_addr == `ADDR_MAX) begin
								read_error <= 1'b1;
								fallback_start <= 1'b1;
								ev_err <= 1'b1;
								flash_output_en_n <= 1'b1;
								flash_chip_sel_n <= 1'b1;
								state_r <= S_FAIL;
							end else begin
								flash_addr <= addr_inc;
								wait_r <= (sync_mode_r || page_inner) ? 3'h1 : first_lat;
							end
						end
					end
				end
				S_WR1: begin
					if (rise_tick) begin
						if (!wr_ph_r) begin
							flash_write_en_n <= 1'b1;
							wr_ph_r <= 1'b1;
						end else begin
							flash_write_en_n <= 1'b0;
							flash_dq_out <= `CMD_CFG_CONFIRM;
							wr_ph_r <= 1'b0;
							state_r <= S_WR2;
						end
					end
				end
				S_WR2: begin
					if (rise_tick) begin
						if (!wr_ph_r) begin
							flash_write_en_n <= 1'b1;
							wr_ph_r <= 1'b1;
						end else begin
							// reread the image from the start in burst mode
							flash_dq_oe <= 1'b0;
							flash_output_en_n <= 1'b0;
							flash_addr <= 29'h00000000;
							addr_valid_n <= 1'b0;
							sync_mode_r <= 1'b1;
							wait_r <= sync_lat;
							ev_sync <= 1'b1;
							state_r <= S_READ;
						end
					end
				end
				S_DONE: begin
					state_r <= S_DONE;
				end
				S_FAIL: begin
					state_r <= S_FAIL;
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// ***********************************
	// apb slave
	// ***********************************
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_hit(paddr);
	assign wr_acc = psel && penable && pwrite && reg_hit(paddr);
	assign rd_setup = psel && !penable && !pwrite;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `CTRL_RESET;
			irq_en_r <= {`IRQ_W{1'b0}};
		end else if (wr_acc) begin
			if (paddr == `OFS_CTRL) begin
				ctrl_r <= pwdata[1:0];
			end
			if (paddr == `OFS_IRQ_EN) begin
				irq_en_r <= pwdata[`IRQ_W-1:0];
			end
		end
	end

	// new events win over a clear in the same cycle
	always @* begin
		irq_stat_nxt = irq_stat_r;
		if (wr_acc && paddr == `OFS_IRQ_CLR) begin
			irq_stat_nxt = irq_stat_nxt & ~pwdata[`IRQ_W-1:0];
		end
		irq_stat_nxt[`IRQ_DONE] = irq_stat_nxt[`IRQ_DONE] | ev_done;
		irq_stat_nxt[`IRQ_ERR] = irq_stat_nxt[`IRQ_ERR] | ev_err;
		irq_stat_nxt[`IRQ_SYNC] = irq_stat_nxt[`IRQ_SYNC] | ev_sync;
		irq_stat_nxt[`IRQ_REJ] = irq_stat_nxt[`IRQ_REJ] | ev_rej;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= {`IRQ_W{1'b0}};
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	assign irq = |(irq_stat_r & irq_en_r);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			case (paddr)
				`OFS_CTRL: prdata <= {30'h00000000, ctrl_r};
				`OFS_STATUS: prdata <= {15'h0000, div_r, first_r, page_r, read_error,
					sync_mode_r, state_r};
				`OFS_IRQ_STAT: prdata <= {28'h0000000, irq_stat_r};
				`OFS_IRQ_EN: prdata <= {28'h0000000, irq_en_r};
				`OFS_ADDR: prdata <= {3'h0, flash_addr};
				default: prdata <= 32'h00000000;
			endcase
		end
	end
endmodule // parallel_flash_read_sequencer

// File: core/pflash_consts.vh
// constants shared by the parallel flash read sequencer
`ifndef PFLASH_CONSTS_VH
`define PFLASH_CONSTS_VH

// ***********************************
// register byte offsets
// ***********************************
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_CLR 8'h0c
`define OFS_IRQ_EN 8'h10
`define OFS_ADDR 8'h14

// ***********************************
// field positions
// ***********************************
`define CTRL_SYNC_EN 0
`define CTRL_SETTING 1
`define IRQ_DONE 0
`define IRQ_ERR 1
`define IRQ_SYNC 2
`define IRQ_REJ 3
`define IRQ_W 4

// ***********************************
// reset values and encodings
// ***********************************
`define CTRL_RESET 2'h0
`define DIV_RESET 8'h04
`define PAGE_1 2'h0
`define PAGE_4 2'h1
`define PAGE_8 2'h2
`define FIRST_1 2'h0
`define ADDR_MAX 29'h1fffffff
`define CMD_CFG_SETUP 16'h0060
`define CMD_CFG_CONFIRM 16'h0003

`endif

// File: core/sync2.v
// two flip-flop synchroniser for signals from outside the pclk domain
module sync2 #(
	parameter WIDTH = 1
) (
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;
endmodule // sync2
